// ==== hw/ifs_pkg.sv ====
`default_nettype none
package ifs_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes of the two FIFOs and of the register port.
  localparam int IFS_DW = 8;
  localparam int IFS_AW = 4;
  localparam int IFS_CW = 5;
  localparam int IFS_FW = 6;
  localparam logic [IFS_CW-1:0] IFS_FULL_COUNT = 5'h10;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses).
  localparam logic [7:0] IFS_OFF_CTRL    = 8'h00;
  localparam logic [7:0] IFS_OFF_TX_DATA = 8'h10;
  localparam logic [7:0] IFS_OFF_RX_DATA = 8'h18;
  localparam logic [7:0] IFS_OFF_TX_THR  = 8'h1c;
  localparam logic [7:0] IFS_OFF_RX_THR  = 8'h20;
  localparam logic [7:0] IFS_OFF_MASK    = 8'h2c;
  localparam logic [7:0] IFS_OFF_RAW     = 8'h30;
  localparam logic [7:0] IFS_OFF_CLEAR   = 8'h38;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of the flag vector and of the control register.
  localparam int IFS_BIT_TX_EMPTY = 0;
  localparam int IFS_BIT_TX_LOW   = 1;
  localparam int IFS_BIT_TX_FULL  = 2;
  localparam int IFS_BIT_TX_OVF   = 3;
  localparam int IFS_BIT_RX_EMPTY = 4;
  localparam int IFS_BIT_RX_HIGH  = 5;
  localparam int IFS_BIT_TX_FLUSH = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [IFS_FW-1:0] IFS_RST_RAW    = 6'h13;
  localparam logic [IFS_FW-1:0] IFS_RST_MASK   = 6'h00;
  localparam logic [IFS_CW-1:0] IFS_RST_TX_THR = 5'h04;
  localparam logic [IFS_CW-1:0] IFS_RST_RX_THR = 5'h0c;
  localparam logic [31:0]       IFS_RST_RDATA  = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        write;
    logic        read;
  } ifs_bus_req_t;

  typedef struct packed {
    logic              push;
    logic [IFS_DW-1:0] data;
  } ifs_link_t;

endpackage
`default_nettype wire

// ==== hw/ifs_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
module ifs_mem import ifs_pkg::*; (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              we,
  input  wire logic [IFS_AW-1:0] waddr,
  input  wire logic [IFS_DW-1:0] wdata,
  input  wire logic [IFS_AW-1:0] raddr,
  output logic      [IFS_DW-1:0] rdata
);

  logic [IFS_DW-1:0] mem [2**IFS_AW];

  ////////////////////////////////////////////////////////////////////////////////
  // Storage; the read register follows the head, with a bypass so that a
  // word written into an empty FIFO is visible one edge later.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (reset) begin
      rdata <= '0;
    end else if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule
`default_nettype wire

// ==== hw/ifs_level.sv ====
`timescale 1ns/100ps
`default_nettype none
module ifs_level import ifs_pkg::*; (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              push,
  input  wire logic              pop,
  input  wire logic              flush,
  output logic      [IFS_AW-1:0] wr_ptr,
  output logic      [IFS_AW-1:0] rd_next,
  output logic      [IFS_CW-1:0] count,
  output logic      [IFS_CW-1:0] count_next
);

  typedef struct packed {
    logic [IFS_AW-1:0] wr;
    logic [IFS_AW-1:0] rd;
    logic [IFS_CW-1:0] cnt;
  } ifs_level_state_t;

  ifs_level_state_t st;
  ifs_level_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // Pointers and fill level; the caller never pushes when full or pops when
  // empty, so no guard is repeated here.
  always_comb begin
    next_st = st;
    if (flush) begin
      next_st = '0;
    end else begin
      if (push) begin
        next_st.wr = IFS_AW'(st.wr + 1'b1);
      end
      if (pop) begin
        next_st.rd = IFS_AW'(st.rd + 1'b1);
      end
      if (push && !pop) begin
        next_st.cnt = IFS_CW'(st.cnt + 1'b1);
      end else if (pop && !push) begin
        next_st.cnt = IFS_CW'(st.cnt - 1'b1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs.
  assign wr_ptr     = st.wr;
  assign rd_next    = next_st.rd;
  assign count      = st.cnt;
  assign count_next = next_st.cnt;

endmodule
`default_nettype wire

// ==== hw/ifs_flags.sv ====
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module ifs_flags import ifs_pkg::*; (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire ifs_bus_req_t      bus,
  output logic      [31:0]       reg_rdata,
  output logic      [IFS_DW-1:0] tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_pop,
  input  wire ifs_link_t         rx_in,
  output logic                   irq
);

  typedef struct packed {
    logic [IFS_FW-1:0] raw;
    logic [IFS_FW-1:0] mask;
    logic [IFS_CW-1:0] tx_thr;
    logic [IFS_CW-1:0] rx_thr;
    logic [31:0]       rdata;
    logic              tx_valid;
    logic              irq;
  } ifs_state_t;

  ifs_state_t st;
  ifs_state_t next_st;

  logic              tx_wr;
  logic              tx_push;
  logic              tx_take;
  logic              tx_flush;
  logic              tx_full;
  logic              rx_rd;
  logic              rx_pop;
  logic              rx_push;
  logic              ovf_clear;
  logic [IFS_AW-1:0] tx_wr_ptr;
  logic [IFS_AW-1:0] tx_rd_next;
  logic [IFS_CW-1:0] tx_count;
  logic [IFS_CW-1:0] tx_count_next;
  logic [IFS_AW-1:0] rx_wr_ptr;
  logic [IFS_AW-1:0] rx_rd_next;
  logic [IFS_CW-1:0] rx_count;
  logic [IFS_CW-1:0] rx_count_next;
  logic [IFS_DW-1:0] rx_head;

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO strobes; full and empty gate the pointers so a bad access cannot
  // corrupt the level counters.
  assign tx_wr     = bus.write && (bus.addr == IFS_OFF_TX_DATA);
  assign tx_full   = (tx_count == IFS_FULL_COUNT);
  assign tx_push   = tx_wr && !tx_full;
  assign tx_take   = tx_pop && st.tx_valid;
  assign tx_flush  = bus.write && (bus.addr == IFS_OFF_CTRL) && bus.wdata[IFS_BIT_TX_FLUSH];
  assign rx_rd     = bus.read && (bus.addr == IFS_OFF_RX_DATA);
  assign rx_pop    = rx_rd && (rx_count != '0);
  assign rx_push   = rx_in.push && (rx_count != IFS_FULL_COUNT);
  assign ovf_clear = bus.write && (bus.addr == IFS_OFF_CLEAR) && bus.wdata[IFS_BIT_TX_OVF];

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO: software fills it, the serial engine drains it.
  ifs_level u_tx_level (
    .clk        (clk),
    .reset      (reset),
    .push       (tx_push),
    .pop        (tx_take),
    .flush      (tx_flush),
    .wr_ptr     (tx_wr_ptr),
    .rd_next    (tx_rd_next),
    .count      (tx_count),
    .count_next (tx_count_next)
  );

  ifs_mem u_tx_mem (
    .clk   (clk),
    .reset (reset),
    .we    (tx_push),
    .waddr (tx_wr_ptr),
    .wdata (bus.wdata[IFS_DW-1:0]),
    .raddr (tx_rd_next),
    .rdata (tx_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Receive FIFO: the serial engine fills it, software drains it. A byte
  // pushed while full is dropped; no flag or interrupt reports that case.
  ifs_level u_rx_level (
    .clk        (clk),
    .reset      (reset),
    .push       (rx_push),
    .pop        (rx_pop),
    .flush      (1'b0),
    .wr_ptr     (rx_wr_ptr),
    .rd_next    (rx_rd_next),
    .count      (rx_count),
    .count_next (rx_count_next)
  );

  ifs_mem u_rx_mem (
    .clk   (clk),
    .reset (reset),
    .we    (rx_push),
    .waddr (rx_wr_ptr),
    .wdata (rx_in.data),
    .raddr (rx_rd_next),
    .rdata (rx_head)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state. Level flags follow the next fill counts, so they move on the
  // same edge as the count and never lag a FIFO access.
  always_comb begin
    next_st = st;
    next_st.raw[IFS_BIT_TX_EMPTY] = (tx_count_next == '0);
    next_st.raw[IFS_BIT_TX_FULL]  = (tx_count_next == IFS_FULL_COUNT);
    next_st.raw[IFS_BIT_RX_EMPTY] = (rx_count_next == '0);
    // Overflow is sticky; a set in the clearing cycle wins.
    if (tx_wr && tx_full) begin
      next_st.raw[IFS_BIT_TX_OVF] = 1'b1;
    end else if (ovf_clear) begin
      next_st.raw[IFS_BIT_TX_OVF] = 1'b0;
    end
    // Register writes; the raw flag register has no write path of its own, only the clear register above clears its overflow bit.
    if (bus.write) begin
      if (bus.addr == IFS_OFF_MASK) begin
        next_st.mask = bus.wdata[IFS_FW-1:0];
      end else if (bus.addr == IFS_OFF_TX_THR) begin
        next_st.tx_thr = bus.wdata[IFS_CW-1:0];
      end else if (bus.addr == IFS_OFF_RX_THR) begin
        next_st.rx_thr = bus.wdata[IFS_CW-1:0];
      end
    end
    next_st.raw[IFS_BIT_TX_LOW]  = (tx_count_next <= next_st.tx_thr);
    next_st.raw[IFS_BIT_RX_HIGH] = (rx_count_next >= next_st.rx_thr);
    // Read data stand only in the cycle after the strobe.
    next_st.rdata = IFS_RST_RDATA;
    if (bus.read) begin
      if (bus.addr == IFS_OFF_RAW) begin
        next_st.rdata = {26'h000_0000, st.raw};
      end else if (bus.addr == IFS_OFF_MASK) begin
        next_st.rdata = {26'h000_0000, st.mask};
      end else if (bus.addr == IFS_OFF_TX_THR) begin
        next_st.rdata = {27'h000_0000, st.tx_thr};
      end else if (bus.addr == IFS_OFF_RX_THR) begin
        next_st.rdata = {27'h000_0000, st.rx_thr};
      end else if (rx_pop) begin
        next_st.rdata = {24'h00_0000, rx_head};
      end
    end
    next_st.tx_valid = (tx_count_next != '0);
    next_st.irq      = |(next_st.raw & next_st.mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk) begin
    if (reset) begin
      st.raw      <= IFS_RST_RAW;
      st.mask     <= IFS_RST_MASK;
      st.tx_thr   <= IFS_RST_TX_THR;
      st.rx_thr   <= IFS_RST_RX_THR;
      st.rdata    <= IFS_RST_RDATA;
      st.tx_valid <= 1'b0;
      st.irq      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs.
  assign reg_rdata = st.rdata;
  assign tx_valid  = st.tx_valid;
  assign irq       = st.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_tx_empty;
    st.raw[IFS_BIT_TX_EMPTY] == (tx_count == '0);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty flag wrong");

  property p_tx_low;
    st.raw[IFS_BIT_TX_LOW] == (tx_count <= st.tx_thr);
  endproperty
  a_tx_low: assert property (p_tx_low) else $error("tx low flag wrong");

  property p_tx_full;
    st.raw[IFS_BIT_TX_FULL] == (tx_count == IFS_FULL_COUNT);
  endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx full flag wrong");

  property p_ovf_set;
    // A drain in the overflow cycle still frees one entry; the dropped word never lands.
    (tx_wr && tx_full) |=> st.raw[IFS_BIT_TX_OVF] &&
      (tx_count == ($past(tx_take) ? IFS_CW'(IFS_FULL_COUNT - 5'h01) : IFS_FULL_COUNT));
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not set");

  property p_ovf_hold;
    (st.raw[IFS_BIT_TX_OVF] && !ovf_clear) |=> st.raw[IFS_BIT_TX_OVF];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");

  property p_rx_empty;
    rx_push ##1 !bus.read |-> ##1 !st.raw[IFS_BIT_RX_EMPTY];
  endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("rx empty flag stuck");

  property p_rx_high;
    st.raw[IFS_BIT_RX_HIGH] == (rx_count >= st.rx_thr);
  endproperty
  a_rx_high: assert property (p_rx_high) else $error("rx high flag wrong");

  property p_mask_wr;
    (bus.write && bus.addr == IFS_OFF_MASK) |=> st.mask == $past(bus.wdata[IFS_FW-1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask not written");

  property p_irq;
    irq == |(st.raw & st.mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_raw_ro;
    (bus.write && bus.addr == IFS_OFF_RAW && !st.raw[IFS_BIT_TX_OVF]) |=>
      !st.raw[IFS_BIT_TX_OVF];
  endproperty
  a_raw_ro: assert property (p_raw_ro) else $error("raw flags written");

  c_ovf:  cover property ($fell(st.raw[IFS_BIT_TX_OVF]));
  c_irq:  cover property ($rose(irq));
  c_high: cover property ($rose(st.raw[IFS_BIT_RX_HIGH]));
  c_fill: cover property ($rose(st.raw[IFS_BIT_TX_FULL]));

endmodule
`default_nettype wire

// ==== test/ifs_link_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Stands in for the serial engine that drains the transmit FIFO and fills the receive FIFO.
module ifs_link_model import ifs_pkg::*; (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [IFS_DW-1:0] tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_pop,
  output var ifs_link_t          rx_in,
  input  wire logic              take,
  input  wire logic              give,
  input  wire logic [IFS_DW-1:0] give_data,
  output logic      [IFS_DW-1:0] got
);
  logic [IFS_DW-1:0] last_rx;

  // A stall is simply a cycle without take, so the engine can be prompt or slow.
  assign tx_pop = take;
  // Outside a push the data lines show the inverse of the last byte, so a stale byte never matches.
  assign rx_in.push = give;
  assign rx_in.data = give ? give_data : ~last_rx;

  ////////////////////////////////////////////////////////////////////////////////
  // Capture each byte handed over and remember the last byte pushed.
  always_ff @(posedge clk) begin
    if (reset) begin
      got     <= 8'h00;
      last_rx <= 8'h00;
    end else begin
      if (tx_pop && tx_valid) got <= tx_data;
      if (give) last_rx <= give_data;
    end
  end
endmodule
`default_nettype wire

// ==== test/i2c_fifo_raw_status_flags_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module i2c_fifo_raw_status_flags_test import ifs_pkg::*;;
  localparam ifs_bus_req_t IDLE = '0;
  logic         clk, reset, take, give, tx_valid, tx_pop, irq, ovf, dirty;
  logic [7:0]   give_data, got, tx_data, e;
  logic [31:0]  reg_rdata, r;
  logic [5:0]   mask;
  logic [4:0]   txthr, rxthr;
  logic [7:0]   txq[$];
  logic [7:0]   rxq[$];
  ifs_bus_req_t bus;
  ifs_link_t    rx_in;
  int           mismatches, n_compared, seed, op;

  ifs_flags ifs_flags_inst (.clk(clk), .reset(reset), .bus(bus), .reg_rdata(reg_rdata),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_pop(tx_pop), .rx_in(rx_in), .irq(irq));
  ifs_link_model ifs_link_model_inst (.clk(clk), .reset(reset), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_pop(tx_pop), .rx_in(rx_in), .take(take), .give(give),
    .give_data(give_data), .got(got));

  ////////////////////////////////////////////////////////////////////////////////
  // Expected flag vector worked out from the queue depths and the programmed thresholds.
  function automatic logic [5:0] exp_raw();
    return {rxq.size() >= rxthr, rxq.size() == 0, ovf, txq.size() == 16,
            txq.size() <= txthr, txq.size() == 0};
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // Every strobe is followed by an idle edge, so no signal is assigned twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
    @(posedge clk);
    bus <= IDLE;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus <= '{addr: a, wdata: 32'h0000_0000, write: 1'b0, read: 1'b1};
    @(posedge clk);
    bus <= IDLE;
    #1 chk(reg_rdata, x);
    @(posedge clk);
  endtask

  task automatic check_flags();
    rd(IFS_OFF_RAW, {26'h0, exp_raw()});
    chk({31'h0, irq}, {31'h0, |(exp_raw() & mask)});
    chk({31'h0, tx_valid}, {31'h0, txq.size() != 0});
  endtask

  // After an overflow the dropped word never lands and the queue keeps its 16 words; software still flushes it before writing again.
  task automatic flush_tx();
    wr(IFS_OFF_CTRL, 32'h0000_0001);
    txq.delete();
    dirty = 1'b0;
  endtask

  task automatic push_tx(input logic [7:0] d);
    wr(IFS_OFF_TX_DATA, {24'h0, d});
    if (txq.size() == 16) begin
      ovf   = 1'b1;
      dirty = 1'b1;
    end else begin
      txq.push_back(d);
    end
  endtask

  // A pop while empty is a refused request and leaves the captured byte alone.
  task automatic pop_tx();
    take <= 1'b1;
    @(posedge clk);
    take <= 1'b0;
    @(posedge clk);
    if (txq.size() != 0) chk({24'h0, got}, {24'h0, txq.pop_front()});
  endtask

  task automatic push_rx(input logic [7:0] d);
    give      <= 1'b1;
    give_data <= d;
    @(posedge clk);
    give <= 1'b0;
    @(posedge clk);
    if (rxq.size() < 16) rxq.push_back(d);
  endtask

  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a watchdog sized well above the length of the sequence below.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset values, fill to overflow, sticky clear, then random traffic.
  initial begin
    bus = IDLE; reset = 1'b1; take = 1'b0; give = 1'b0; give_data = 8'h00;
    mismatches = 0; n_compared = 0; seed = 21964;
    mask = 6'h00; txthr = 5'h04; rxthr = 5'h0c; ovf = 1'b0; dirty = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(IFS_OFF_RAW, 32'h0000_0013);
    rd(IFS_OFF_MASK, 32'h0000_0000);
    mask = 6'h3f;
    wr(IFS_OFF_MASK, 32'hffff_ffff);
    for (int i = 0; i < 17; i++) begin
      push_tx($random(seed));
      check_flags();
    end
    wr(IFS_OFF_RAW, 32'h0000_0000);
    check_flags();
    wr(IFS_OFF_CLEAR, 32'hffff_fff7);
    check_flags();
    repeat (8) begin
      pop_tx();
      check_flags();
    end
    flush_tx();
    check_flags();
    wr(IFS_OFF_CLEAR, 32'h0000_0008);
    ovf = 1'b0;
    check_flags();
    repeat (400) begin
      r  = $random(seed);
      op = $unsigned($random(seed)) % 10;
      case (op)
        0, 1, 2: begin
          if (dirty) flush_tx();
          else push_tx(r[7:0]);
        end
        3: pop_tx();
        4, 5: push_rx(r[7:0]);
        6: begin
          e = (rxq.size() != 0) ? rxq.pop_front() : 8'h00;
          rd(IFS_OFF_RX_DATA, {24'h0, e});
        end
        7: begin
          if (r[8]) begin
            txthr = r[4:0] % 5'h11;
            wr(IFS_OFF_TX_THR, {27'h0, txthr});
          end else begin
            rxthr = r[4:0] % 5'h11;
            wr(IFS_OFF_RX_THR, {27'h0, rxthr});
          end
        end
        8: begin
          mask = r[5:0];
          wr(IFS_OFF_MASK, r);
          rd(IFS_OFF_MASK, {26'h0, mask});
        end
        default: begin
          if (r[7:4] == 4'h0) begin
            flush_tx();
          end else begin
            wr(IFS_OFF_CLEAR, r);
            if (r[3]) ovf = 1'b0;
          end
        end
      endcase
      check_flags();
    end
    rd(8'h3c, 32'h0000_0000);
    give_verdict();
  end
endmodule
`default_nettype wire
